// >>> hdl/onc_pkg.sv
// on/off controller configuration block: constants, field layout, types
// assumes a 25 MHz controller clock and pins sampled through synchronisers
package onc_pkg;

   localparam logic [6:0] I2C_ADDR      = 7'h3C;
   localparam logic [7:0] CFG1_ADDR     = 8'h41;
   localparam logic [7:0] CFG2_ADDR     = 8'h42;

   localparam int C1_SFT  = 7;
   localparam int C1_RSVD = 6;
   localparam int C1_MRT  = 3;
   localparam int C1_SLP  = 2;
   localparam int C1_PWR  = 1;
   localparam int C1_DLY  = 0;
   localparam int C2_SWK  = 7;
   localparam int C2_WWK  = 6;
   localparam int C2_LPM  = 5;
   localparam int C2_ADP  = 4;
   localparam int C2_COV  = 3;
   localparam int C2_AL1  = 2;
   localparam int C2_AL2  = 1;
   localparam int C2_KEY  = 0;

   // command bits only ever get set by a write, never cleared by one
   localparam logic [7:0] CFG1_CMD_MASK = 8'h82;
   localparam logic [7:0] CFG1_OTP_MASK = 8'h79;
   localparam logic [7:0] CFG1_FIXED    = 8'h00;
   localparam logic [7:0] CFG2_OTP_MASK = 8'h18;
   localparam logic [7:0] CFG2_FIXED    = 8'h07;
   localparam logic [7:0] CFG1_OTP_DEF  = 8'h40;
   localparam logic [7:0] CFG2_OTP_DEF  = 8'h00;

   localparam logic [3:0] MRT_SEC [0:7] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'hA, 4'hC};

   localparam int unsigned CLK_HZ            = 25_000_000;
   localparam int unsigned SEC_S             = 1;
   localparam int unsigned KEY_DELAY_S       = 1;
   localparam int unsigned SEC_CYC_DEF       = SEC_S * CLK_HZ;
   localparam int unsigned KEY_DELAY_CYC_DEF = KEY_DELAY_S * CLK_HZ;
   localparam int unsigned DEBOUNCE_CYC_DEF  = 16;
   localparam int          CNT_W             = 25;

   localparam int P_SCL = 0;
   localparam int P_SDA = 1;
   localparam int P_KEY = 2;
   localparam int P_SLP = 3;
   localparam int P_ADP = 4;
   localparam int P_COV = 5;
   localparam int NPIN  = 6;

   typedef enum logic [1:0] {
      S_IDLE = 2'b01,
      S_SHUT = 2'b10
   } onc_sst_t;

   typedef enum logic [6:0] {
      I_IDLE  = 7'b0000001,
      I_ADDR  = 7'b0000010,
      I_RX    = 7'b0000100,
      I_ACKP  = 7'b0001000,
      I_ACK   = 7'b0010000,
      I_TX    = 7'b0100000,
      I_TXACK = 7'b1000000
   } onc_ist_t;

   typedef struct packed {
      logic alarm_one_event;
      logic alarm_two_event;
      logic watchdog_expired;
      logic off_signal;
      logic shutdown_done;
      logic reset_output;
   } onc_evt_t;

   typedef struct packed {
      logic shutdown_start;
      logic shutdown_reset;
      logic power_cycle;
      logic restart;
      logic wakeup;
      logic seq_one_enable;
   } onc_seq_t;

   typedef struct packed {
      logic [NPIN-1:0]  s1;
      logic [NPIN-1:0]  s2;
      logic [NPIN-1:0]  s3;
      logic [NPIN-1:0]  pin;
      logic [NPIN-1:0]  pin_d;
      logic [7:0]       cfg1;
      logic [7:0]       cfg2;
      onc_sst_t         st;
      logic             sreset;
      logic             pcycle;
      logic             shut_pulse;
      logic             restart_pulse;
      logic             wake_pulse;
      logic             warn_pulse;
      logic             mreset_pulse;
      logic             latch;
      logic             off_d;
      logic             sleep;
      logic             lpm;
      logic [CNT_W-1:0] db_cnt;
      logic             key_db;
      logic [CNT_W-1:0] dly_cnt;
      logic             key_out;
      logic [CNT_W-1:0] pre_cnt;
      logic [3:0]       secs;
      onc_ist_t         ist;
      logic [7:0]       sh;
      logic [2:0]       cnt;
      logic             rw;
      logic             phase;
      logic [7:0]       ptr;
      logic             oe;
   } onc_state_t;

endpackage

// >>> hdl/onc_controller.sv
// on/off controller configuration and command logic with its own i2c target
// assumes sequencers answer shutdown_start with one shutdown_done pulse
`timescale 1ns/1ps
module onc_controller
   import onc_pkg::*;
#(
   parameter logic [7:0]  OTP_CFG1      = CFG1_OTP_DEF,
   parameter logic [7:0]  OTP_CFG2      = CFG2_OTP_DEF,
   parameter int unsigned SEC_CYC       = SEC_CYC_DEF,
   parameter int unsigned KEY_DELAY_CYC = KEY_DELAY_CYC_DEF,
   parameter int unsigned DEBOUNCE_CYC  = DEBOUNCE_CYC_DEF
)(
   input  wire logic     clk,
   input  wire logic     rstn,
   input  wire logic     i2c_scl,
   input  wire logic     i2c_sda_i,
   output logic          i2c_sda_o,
   output logic          i2c_sda_oe,
   input  wire logic     power_key_input,
   input  wire logic     sleep_request_input,
   input  wire logic     adapter_present,
   input  wire logic     cover_input,
   input  wire onc_evt_t sys_evt,
   output onc_seq_t      seq_ctl,
   output logic          sleep_active,
   output logic          sleep_lowpower_signal,
   output logic          lowpower_mode_bus,
   output logic          power_key_level,
   output logic          manual_reset_warning,
   output logic          manual_reset_expired
);

   // reset values: fixed bits plus the factory bits taken from the otp words
   localparam logic [7:0]       RST1    = CFG1_FIXED | (OTP_CFG1 & CFG1_OTP_MASK);
   localparam logic [7:0]       RST2    = CFG2_FIXED | (OTP_CFG2 & CFG2_OTP_MASK);
   localparam logic [CNT_W-1:0] SEC_LIM = CNT_W'(SEC_CYC - 1);
   localparam logic [CNT_W-1:0] DLY_LIM = CNT_W'(KEY_DELAY_CYC);
   localparam logic [CNT_W-1:0] DB_LIM  = CNT_W'(DEBOUNCE_CYC - 1);

   onc_state_t r_reg;
   onc_state_t r_next;

   function automatic logic [7:0] rd_reg(input logic [7:0] a, input logic [7:0] c1, input logic [7:0] c2);
      // unmapped pointers read as zero; writes to them are acked and dropped
      rd_reg = 8'h00;
      if (a == CFG1_ADDR) begin
         rd_reg = c1;
      end else if (a == CFG2_ADDR) begin
         rd_reg = c2;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic       scl_r;
      logic       scl_f;
      logic       i2c_go;
      logic       i2c_end;
      logic       sda;
      logic       wr1;
      logic       wr2;
      logic [7:0] wd;
      logic [7:0] byte_in;
      logic       key_raw;
      logic       key_new;
      logic       wake;
      logic       off_rise;
      logic [3:0] nsecs;
      logic [2:0] mrt;
      scl_r   = 1'b0;
      scl_f   = 1'b0;
      i2c_go  = 1'b0;
      i2c_end = 1'b0;
      sda     = 1'b0;
      wr1     = 1'b0;
      wr2     = 1'b0;
      wd      = 8'h00;
      byte_in = 8'h00;
      key_raw = 1'b0;
      key_new = 1'b0;
      wake    = 1'b0;
      nsecs   = 4'h0;
      mrt     = 3'h0;
      off_rise = 1'b0;
      r_next  = r_reg;
      // a pin level counts once the second and third stages agree
      r_next.s1    = {cover_input, adapter_present, sleep_request_input, power_key_input, i2c_sda_i, i2c_scl};
      r_next.s2    = r_reg.s1;
      r_next.s3    = r_reg.s2;
      r_next.pin   = (r_reg.s2 & r_reg.s3) | (r_reg.pin & (r_reg.s2 ^ r_reg.s3));
      r_next.pin_d = r_reg.pin;
      r_next.shut_pulse    = 1'b0;
      r_next.restart_pulse = 1'b0;
      r_next.wake_pulse    = 1'b0;
      r_next.warn_pulse    = 1'b0;
      r_next.mreset_pulse  = 1'b0;
      r_next.off_d         = sys_evt.off_signal;
      off_rise = sys_evt.off_signal & ~r_reg.off_d;

      ////////////////////////////////////////////////////////////////////////
      // i2c target: sample on scl rise, drive sda after scl fall
      // no clock stretching: each scl phase must outlast the four-cycle
      // synchroniser and edge delay, or bits are missed
      sda     = r_reg.pin[P_SDA];
      scl_r   = r_reg.pin[P_SCL] & ~r_reg.pin_d[P_SCL];
      scl_f   = ~r_reg.pin[P_SCL] & r_reg.pin_d[P_SCL];
      i2c_go  = r_reg.pin[P_SCL] & r_reg.pin_d[P_SCL] & r_reg.pin_d[P_SDA] & ~sda;
      i2c_end = r_reg.pin[P_SCL] & r_reg.pin_d[P_SCL] & ~r_reg.pin_d[P_SDA] & sda;
      byte_in = {r_reg.sh[6:0], sda};
      if (i2c_go) begin
         r_next.ist   = I_ADDR;
         r_next.cnt   = 3'h0;
         r_next.phase = 1'b0;
         r_next.oe    = 1'b0;
      end else if (i2c_end) begin
         r_next.ist = I_IDLE;
         r_next.oe  = 1'b0;
      end else begin
         unique case (r_reg.ist)
            I_IDLE: begin
               r_next.oe = 1'b0;
            end
            I_ADDR: begin
               if (scl_r) begin
                  r_next.sh  = byte_in;
                  r_next.cnt = r_reg.cnt + 3'h1;
                  if (r_reg.cnt == 3'h7) begin
                     r_next.rw  = sda;
                     r_next.ist = (r_reg.sh[6:0] == I2C_ADDR) ? I_ACKP : I_IDLE;
                  end
               end
            end
            I_RX: begin
               if (scl_r) begin
                  r_next.sh  = byte_in;
                  r_next.cnt = r_reg.cnt + 3'h1;
                  if (r_reg.cnt == 3'h7) begin
                     r_next.ist = I_ACKP;
                     if (!r_reg.phase) begin
                        r_next.ptr   = byte_in;
                        r_next.phase = 1'b1;
                     end else begin
                        wr1        = (r_reg.ptr == CFG1_ADDR);
                        wr2        = (r_reg.ptr == CFG2_ADDR);
                        wd         = byte_in;
                        r_next.ptr = r_reg.ptr + 8'h01;
                     end
                  end
               end
            end
            I_ACKP: begin
               if (scl_f) begin
                  r_next.oe  = 1'b1;
                  r_next.ist = I_ACK;
               end
            end
            I_ACK: begin
               if (scl_f) begin
                  r_next.cnt = 3'h0;
                  r_next.oe  = 1'b0;
                  r_next.ist = I_RX;
                  if (r_reg.rw) begin
                     // fetched at the ack fall so the first bit is out in time
                     r_next.sh  = rd_reg(r_reg.ptr, r_reg.cfg1, r_reg.cfg2);
                     r_next.oe  = ~r_next.sh[7];
                     r_next.ptr = r_reg.ptr + 8'h01;
                     r_next.ist = I_TX;
                  end
               end
            end
            I_TX: begin
               if (scl_r) begin
                  r_next.cnt = r_reg.cnt + 3'h1;
                  if (r_reg.cnt == 3'h7) begin
                     r_next.ist = I_TXACK;
                  end
               end else if (scl_f) begin
                  r_next.sh = {r_reg.sh[6:0], 1'b0};
                  r_next.oe = ~r_reg.sh[6];
               end
            end
            I_TXACK: begin
               if (scl_f) begin
                  r_next.oe = 1'b0;
               end else if (scl_r) begin
                  r_next.ist = sda ? I_IDLE : I_ACK;
               end
            end
            default: begin
               r_next.ist = I_IDLE;
               r_next.oe  = 1'b0;
            end
         endcase
      end

      ////////////////////////////////////////////////////////////////////////
      // power key: debounce, optional extra delay, hold timer
      // the hold timer runs on the debounced level, so the extra delay
      // does not stretch the manual reset or warning times
      key_raw = r_reg.pin[P_KEY];
      if (key_raw == r_reg.key_db) begin
         r_next.db_cnt = '0;
      end else if (r_reg.db_cnt >= DB_LIM) begin
         r_next.db_cnt = '0;
         r_next.key_db = key_raw;
      end else begin
         r_next.db_cnt = r_reg.db_cnt + CNT_W'(1);
      end
      if (!r_reg.key_db) begin
         r_next.dly_cnt = '0;
      end else if (r_reg.dly_cnt != DLY_LIM) begin
         r_next.dly_cnt = r_reg.dly_cnt + CNT_W'(1);
      end
      key_new        = r_reg.key_db & (~r_reg.cfg1[C1_DLY] | (r_reg.dly_cnt == DLY_LIM));
      r_next.key_out = key_new;
      mrt            = r_reg.cfg1[C1_MRT +: 3];
      if (!r_reg.key_db) begin
         r_next.pre_cnt = '0;
         r_next.secs    = 4'h0;
      end else if (r_reg.pre_cnt == SEC_LIM) begin
         r_next.pre_cnt = '0;
         // seconds saturate so a key held for minutes cannot fire again
         nsecs          = (r_reg.secs == 4'hF) ? 4'hF : r_reg.secs + 4'h1;
         r_next.secs    = nsecs;
         r_next.mreset_pulse = (nsecs == MRT_SEC[mrt]) & (r_reg.secs != nsecs);
         if (mrt != 3'h0) begin
            r_next.warn_pulse = (nsecs == MRT_SEC[mrt - 3'h1]) & (r_reg.secs != nsecs);
         end
      end else begin
         r_next.pre_cnt = r_reg.pre_cnt + CNT_W'(1);
      end

      ////////////////////////////////////////////////////////////////////////
      // wakeup sources, each behind its own enable
      // cover wakes on either edge, adapter only on arrival
      wake = (r_reg.cfg2[C2_ADP] & r_reg.pin[P_ADP] & ~r_reg.pin_d[P_ADP])
           | (r_reg.cfg2[C2_COV] & (r_reg.pin[P_COV] ^ r_reg.pin_d[P_COV]))
           | (r_reg.cfg2[C2_AL1] & sys_evt.alarm_one_event)
           | (r_reg.cfg2[C2_AL2] & sys_evt.alarm_two_event)
           | (r_reg.cfg2[C2_KEY] & key_new & ~r_reg.key_out);
      r_next.wake_pulse = wake;

      // hardware clears first, so a write landing in the same cycle wins
      if (off_rise | wake) begin
         r_next.cfg1[C1_SLP] = 1'b0;
      end
      if (off_rise) begin
         r_next.cfg2[C2_LPM] = 1'b0;
      end
      if (wr1) begin
         // the reserved bit is stored as written; host is expected to write one
         r_next.cfg1 = wd | (r_reg.cfg1 & CFG1_CMD_MASK);
         if (wd[C1_SLP]) begin
            r_next.latch = 1'b0;
         end
      end
      if (wr2) begin
         r_next.cfg2 = wd;
      end
      // a wake beside a sleep-enable write keeps sequencer one on
      if (wake) begin
         r_next.latch = 1'b1;
      end

      ////////////////////////////////////////////////////////////////////////
      // global shutdown; soft reset outranks watchdog, which outranks power-off
      // a watchdog pulse that lands mid-shutdown is dropped, and requests
      // written meanwhile are wiped by the reload
      unique case (r_reg.st)
         S_IDLE: begin
            if (r_reg.cfg1[C1_SFT] | r_reg.cfg1[C1_PWR] | sys_evt.watchdog_expired) begin
               r_next.st         = S_SHUT;
               r_next.shut_pulse = 1'b1;
               r_next.sreset     = r_reg.cfg1[C1_SFT] | sys_evt.watchdog_expired;
               if (r_reg.cfg1[C1_SFT]) begin
                  r_next.pcycle = r_reg.cfg2[C2_SWK];
               end else if (sys_evt.watchdog_expired) begin
                  r_next.pcycle = r_reg.cfg2[C2_WWK];
               end else begin
                  r_next.pcycle = 1'b0;
               end
            end
         end
         S_SHUT: begin
            if (sys_evt.shutdown_done) begin
               r_next.st            = S_IDLE;
               r_next.restart_pulse = r_reg.pcycle;
               r_next.sreset        = 1'b0;
               r_next.pcycle        = 1'b0;
               r_next.cfg1          = RST1;
               r_next.cfg2          = RST2;
            end
         end
         default: begin
            r_next.st = S_IDLE;
         end
      endcase

      ////////////////////////////////////////////////////////////////////////
      // the request pin is active low; both results are one clock late
      r_next.sleep = r_reg.cfg1[C1_SLP] & ~r_reg.latch & ~r_reg.pin[P_SLP];
      r_next.lpm   = r_reg.cfg2[C2_LPM] & ~sys_evt.reset_output & ~r_reg.pin[P_SLP];
   end

   // one register stage for the whole state struct

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r_reg       <= '0;
         // bus pins reset to their idle high level, so no false start follows
         r_reg.s1    <= 6'h03;
         r_reg.s2    <= 6'h03;
         r_reg.s3    <= 6'h03;
         r_reg.pin   <= 6'h03;
         r_reg.pin_d <= 6'h03;
         r_reg.cfg1  <= RST1;
         r_reg.cfg2  <= RST2;
         r_reg.st    <= S_IDLE;
         r_reg.ist   <= I_IDLE;
      end else begin
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign i2c_sda_o             = 1'b0;
   assign i2c_sda_oe            = r_reg.oe;
   assign seq_ctl.shutdown_start = r_reg.shut_pulse;
   assign seq_ctl.shutdown_reset = r_reg.sreset;
   assign seq_ctl.power_cycle    = r_reg.pcycle;
   assign seq_ctl.restart        = r_reg.restart_pulse;
   assign seq_ctl.wakeup         = r_reg.wake_pulse;
   assign seq_ctl.seq_one_enable = r_reg.latch;
   assign sleep_active          = r_reg.sleep;
   assign sleep_lowpower_signal = r_reg.lpm;
   assign lowpower_mode_bus     = r_reg.lpm;
   assign power_key_level       = r_reg.key_out;
   assign manual_reset_warning  = r_reg.warn_pulse;
   assign manual_reset_expired  = r_reg.mreset_pulse;

endmodule

// >>> test/onc_host_model.sv
// i2c host model: bit-banged master on scl and the shared data wire
// assumes the target only ever pulls the wire low, a pull-up does the rest
`timescale 1ns/1ps
module onc_host_model
   import onc_pkg::*;
(
   input  wire logic clk,
   input  wire logic sda_o,
   input  wire logic sda_oe,
   output logic      scl,
   output logic      sda
);
   logic drv = 1'b1;
   // pull-up wire: low while either party pulls it down
   assign sda = drv & ~(sda_oe & ~sda_o);
   initial scl = 1'b1;
////////////////////////////////////////////////////////
   task automatic half();
      repeat (8) @(negedge clk);
   endtask
   task automatic bit_io(input logic b, output logic r);
      drv = b;
      half();
      scl = 1'b1;
      half();
      r = sda;
      scl = 1'b0;
      half();
   endtask
   task automatic byte_io(input logic [7:0] d, input logic ack, output logic [7:0] q, output logic n);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(ack, n);
   endtask
   task automatic start();
      drv = 1'b1;
      half();
      scl = 1'b1;
      half();
      drv = 1'b0;
      half();
      scl = 1'b0;
      half();
   endtask
   task automatic stop();
      drv = 1'b0;
      half();
      scl = 1'b1;
      half();
      drv = 1'b1;
      half();
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, output logic ok);
      logic [7:0] q;
      logic       n0, n1, n2;
      start();
      byte_io({a, 1'b0}, 1'b1, q, n0);
      byte_io(p, 1'b1, q, n1);
      byte_io(d, 1'b1, q, n2);
      stop();
      ok = ~(n0 | n1 | n2);
   endtask
   // single-byte read, closed with a nack as the bus requires
   task automatic rd(input logic [7:0] p, output logic [7:0] q);
      logic n;
      start();
      byte_io({I2C_ADDR, 1'b0}, 1'b1, q, n);
      byte_io(p, 1'b1, q, n);
      start();
      byte_io({I2C_ADDR, 1'b1}, 1'b1, q, n);
      byte_io(8'hFF, 1'b1, q, n);
      stop();
   endtask
endmodule

// >>> test/onc_controller_chk.sv
// assertion checker on the on/off controller ports
// assumes one shutdown_done pulse answers each shutdown_start
`timescale 1ns/1ps
module onc_controller_chk
   import onc_pkg::*;
(
   input wire logic     clk,
   input wire logic     rstn,
   input wire onc_evt_t sys_evt,
   input wire onc_seq_t seq_ctl,
   input wire logic     sleep_active,
   input wire logic     sleep_lowpower_signal,
   input wire logic     lowpower_mode_bus,
   input wire logic     power_key_level,
   input wire logic     manual_reset_warning
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // high from the cycle after shutdown_start until shutdown_done is taken
   logic busy_reg;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) busy_reg <= 1'b0;
      else if (seq_ctl.shutdown_start) busy_reg <= 1'b1;
      else if (sys_evt.shutdown_done) busy_reg <= 1'b0;
   end
////////////////////////////////////////////////////////
   start_pulse_a: assert property (seq_ctl.shutdown_start |=> !seq_ctl.shutdown_start)
      else $error("shutdown start not a pulse");
   hold_ctl_a: assert property (busy_reg && !sys_evt.shutdown_done |=>
      $stable(seq_ctl.shutdown_reset) && $stable(seq_ctl.power_cycle)) else $error("shutdown kind changed");
   done_quiet_a: assert property (busy_reg && sys_evt.shutdown_done |=> !seq_ctl.shutdown_start [*3])
      else $error("shutdown restarted by itself");
   restart_a: assert property (seq_ctl.restart |->
      $past(sys_evt.shutdown_done) && $past(seq_ctl.power_cycle)) else $error("restart without cause");
   wd_reset_a: assert property (sys_evt.watchdog_expired && !busy_reg && !seq_ctl.shutdown_start |=>
      seq_ctl.shutdown_start && seq_ctl.shutdown_reset) else $error("watchdog shutdown missing");
   lp_reset_a: assert property (sys_evt.reset_output |=> !sleep_lowpower_signal)
      else $error("low power during reset");
   lp_pair_a: assert property (sleep_lowpower_signal == lowpower_mode_bus)
      else $error("low power outputs differ");
   wake_latch_a: assert property (seq_ctl.wakeup |-> seq_ctl.seq_one_enable ##1 !seq_ctl.wakeup)
      else $error("wakeup without latch");
   no_sleep_a: assert property (seq_ctl.seq_one_enable |=> !sleep_active)
      else $error("sleep while latch set");
   warn_key_a: assert property (manual_reset_warning |-> power_key_level)
      else $error("warning without key");
   cover property (seq_ctl.restart);
   cover property (seq_ctl.wakeup);
   cover property (manual_reset_warning);
endmodule
bind onc_controller onc_controller_chk u_chk (
   .clk                   (clk),
   .rstn                  (rstn),
   .sys_evt               (sys_evt),
   .seq_ctl               (seq_ctl),
   .sleep_active          (sleep_active),
   .sleep_lowpower_signal (sleep_lowpower_signal),
   .lowpower_mode_bus     (lowpower_mode_bus),
   .power_key_level       (power_key_level),
   .manual_reset_warning  (manual_reset_warning)
);

// >>> test/test_onc_controller.sv
// self-checking bench for the on/off controller configuration block
// assumes the host model on i2c; the bench plays sequencers, alarms and pins
`timescale 1ns/1ps
module test_onc_controller
   import onc_pkg::*;
;
   localparam int SEC = 20;
   localparam int KD  = 10;
   logic       clk  = 1'b0;
   logic       rstn = 1'b0;
   logic       pk   = 1'b0;
   logic       sr   = 1'b1;
   logic       ap   = 1'b0;
   logic       cv   = 1'b0;
   onc_evt_t   ev   = '0;
   onc_seq_t   sq;
   logic       scl, sda, sda_o, sda_oe, slp, lps, lpb, pkl, warn, mexp, ok, s_rst;
   logic       pkl_d = 1'b0;
   logic [7:0] v;
   int         seed = 50797;
   int         n_errors = 0;
   int         n_tests = 0;
   int         cyc = 0;
   int         n_wake = 0, n_rst = 0, n_shut = 0, n_warn = 0, n_exp = 0;
   int         t_key, t_warn, t_exp, tp, lat0, lat, w0, r0, h;
   always #20 clk = ~clk;
   onc_controller #(.SEC_CYC(SEC), .KEY_DELAY_CYC(KD), .DEBOUNCE_CYC(4)) dut (
      .clk(clk), .rstn(rstn), .i2c_scl(scl), .i2c_sda_i(sda), .i2c_sda_o(sda_o), .i2c_sda_oe(sda_oe),
      .power_key_input(pk), .sleep_request_input(sr), .adapter_present(ap), .cover_input(cv),
      .sys_evt(ev), .seq_ctl(sq), .sleep_active(slp), .sleep_lowpower_signal(lps), .lowpower_mode_bus(lpb),
      .power_key_level(pkl), .manual_reset_warning(warn), .manual_reset_expired(mexp));
   onc_host_model host (.clk(clk), .sda_o(sda_o), .sda_oe(sda_oe), .scl(scl), .sda(sda));
////////////////////////////////////////////////////////
   task automatic give_verdict();
      if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   task automatic ns(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wreg(input logic [7:0] p, input logic [7:0] d);
      host.wr(I2C_ADDR, p, d, ok);
      check("write ack", ok, 1'b1);
   endtask
   task automatic rreg(input logic [7:0] p, input logic [7:0] e, input string nm);
      logic [7:0] q;
      host.rd(p, q);
      check(nm, q, e);
   endtask
   function automatic int hold_s(input int c);
      return c < 5 ? c + 2 : 2 * c - 2;
   endfunction
   // sequencers finish a shutdown after a random while
   always @(negedge clk) begin
      if (sq.shutdown_start === 1'b1) begin
         ns(1 + $unsigned($random(seed)) % 8);
         ev.shutdown_done = 1'b1;
         ns(1);
         ev.shutdown_done = 1'b0;
      end
   end
   always @(negedge clk) begin
      if (pkl === 1'b1 && pkl_d !== 1'b1) t_key = cyc;
      pkl_d = pkl;
      if (warn === 1'b1) begin
         n_warn++;
         t_warn = cyc;
      end
      if (mexp === 1'b1) begin
         n_exp++;
         t_exp = cyc;
      end
      if (sq.wakeup === 1'b1) n_wake++;
      if (sq.restart === 1'b1) n_rst++;
      if (sq.shutdown_start === 1'b1) begin
         n_shut++;
         s_rst = sq.shutdown_reset;
      end
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 100000) begin
         n_errors++;
         give_verdict();
      end
   end
   initial begin
      ns(16);
      rstn = 1'b1;
      ns(4);
      rreg(8'h41, 8'h40, "cfg1 reset");
      rreg(8'h42, 8'h07, "cfg2 reset");
      host.wr(7'h3D, 8'h42, 8'h00, ok);
      check("foreign address", ok, 1'b0);
      wreg(8'h43, 8'hFF);
      rreg(8'h43, 8'h00, "unmapped");
      for (int i = 0; i < 3; i++) begin
         v = 8'($random(seed));
         wreg(8'h42, v);
         rreg(8'h42, v, "cfg2 rw");
      end
      for (int s = 0; s < 5; s++) begin
         for (int e = 0; e < 2; e++) begin
            wreg(8'h42, e ? 8'(1 << s) : 8'h00);
            wreg(8'h41, 8'h44);
            w0 = n_wake;
            case (s)
               0: pk = 1'b1;
               1: ev.alarm_two_event = 1'b1;
               2: ev.alarm_one_event = 1'b1;
               3: cv = ~cv;
               default: ap = 1'b1;
            endcase
            ns(1);
            ev.alarm_one_event = 1'b0;
            ev.alarm_two_event = 1'b0;
            ns(30);
            pk = 1'b0;
            ap = 1'b0;
            ns(30);
            check("wake count", n_wake - w0, e);
            check("latch", sq.seq_one_enable, e);
            rreg(8'h41, e ? 8'h40 : 8'h44, "wake clears sleep");
         end
      end
      wreg(8'h41, 8'h44);
      wreg(8'h41, 8'h40);
      sr = 1'b0;
      ns(10);
      check("sleep masked", slp, 1'b0);
      sr = 1'b1;
      wreg(8'h41, 8'h44);
      sr = 1'b0;
      ns(10);
      check("sleep entry", slp, 1'b1);
      check("lowpower masked", lps, 1'b0);
      wreg(8'h42, 8'h20);
      check("lowpower on", lpb, 1'b1);
      ev.reset_output = 1'b1;
      ns(2);
      check("lowpower in reset", lps, 1'b0);
      ev.off_signal = 1'b1;
      ns(2);
      rreg(8'h41, 8'h40, "off clears sleep");
      rreg(8'h42, 8'h00, "off clears unmask");
      ev = '0;
      sr = 1'b1;
      // power off, soft reset, both bits, watchdog; each with restart off then on
      for (int j = 0; j < 8; j++) begin
         wreg(8'h42, {j[2], j[2], 6'h00});
         w0 = n_shut;
         r0 = n_rst;
         if (j[1:0] == 2'd3) begin
            ev.watchdog_expired = 1'b1;
            ns(1);
            ev.watchdog_expired = 1'b0;
         end else begin
            wreg(8'h41, j[1:0] == 2'd0 ? 8'h42 : j[1:0] == 2'd1 ? 8'hC0 : 8'hC2);
         end
         ns(20);
         check("shutdown", n_shut - w0, 1);
         check("reset kind", s_rst, j[1:0] != 2'd0);
         check("restart", n_rst - r0, j[2] && j[1:0] != 2'd0);
         rreg(8'h41, 8'h40, "reload");
      end
      for (int c = 0; c < 8; c++) begin
         v = {2'b01, c[2:0], 2'b00, c[0]};
         wreg(8'h41, v);
         rreg(8'h41, v, "cfg1 rw");
         h = hold_s(c) * SEC;
         w0 = n_warn;
         r0 = n_exp;
         pk = 1'b1;
         tp = cyc;
         ns(h + 60);
         pk = 1'b0;
         ns(30);
         lat = t_key - tp;
         if (c == 0) lat0 = lat;
         if (c[0]) check("key delay", lat - lat0, KD);
         check("expire", n_exp - r0, 1);
         check("expire time", $unsigned(t_exp - tp - lat0 - h + 2) <= 4, 1'b1);
         check("warn", n_warn - w0, c != 0);
         if (c != 0) check("warn time", $unsigned(t_warn - tp - lat0 - hold_s(c - 1) * SEC + 2) <= 4, 1'b1);
      end
      give_verdict();
   end
endmodule
